//--- pfs_consts.svh
// Offsets, pin and field widths, reset values and bus codes of the pin selector.
`ifndef PFS_CONSTS_SVH
`define PFS_CONSTS_SVH
`define PFS_PINS 8
`define PFS_FIELD_W 2
`define PFS_SEL_W 16
`define PFS_OFF_SEL_A 32'h0000_0000
`define PFS_OFF_SEL_B 32'h0000_0004
`define PFS_OFF_DAT_A 32'h0000_0008
`define PFS_OFF_DAT_B 32'h0000_000C
`define PFS_SEL_RESET 16'h0000
`define PFS_DAT_RESET 8'h00
`define PFS_HTRANS_NONSEQ_BIT 1
`define PFS_HSIZE_WORD 3'h2
`define PFS_HRESP_OKAY 1'b0
`endif

//--- pfs_pkg.sv
// Types shared by the pin function selector.
`include "pfs_consts.svh"
package pfs_pkg;
	typedef enum logic [1:0] {
		PFS_MODE_ALT = 2'h0,
		PFS_MODE_OUT = 2'h1,
		PFS_MODE_IN_PU = 2'h2,
		PFS_MODE_IN_NOPU = 2'h3
	} pfs_mode_t;
	typedef enum logic [1:0] {
		PFS_REG_SEL_A = 2'h0,
		PFS_REG_SEL_B = 2'h1,
		PFS_REG_DAT_A = 2'h2,
		PFS_REG_DAT_B = 2'h3
	} pfs_reg_t;
	typedef struct packed {
		logic [`PFS_PINS-1:0] out;
		logic [`PFS_PINS-1:0] oe;
		logic [`PFS_PINS-1:0] pu;
	} pfs_pad_t;
	typedef struct packed {
		logic [`PFS_PINS-1:0] out;
		logic [`PFS_PINS-1:0] oe;
	} pfs_alt_t;
endpackage : pfs_pkg

//--- pfs_top.sv
// Pin function selector for ports A and B with an AHB-Lite register slave.
//
// Summary of operation
// - Port A select register, 2 bits per pin.
// - Port B select register, same field layout.
// - Mode 00 routes alternate function; reset zero.
// - 01 drives output; 10 input with pull-up.
// - Mode 11 is input without pull-up.
// - Pull-up only in input pull-up mode.
`timescale 1ns/1ns
`include "pfs_consts.svh"
module pfs_top #(
	parameter int PINS = `PFS_PINS
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [1:0][`PFS_PINS-1:0] pad_in,
	output pfs_pkg::pfs_pad_t [1:0] pad,
	input wire pfs_pkg::pfs_alt_t [1:0] alt,
	output logic [1:0][`PFS_PINS-1:0] alt_in
);

	// Eight two-bit fields fill a sixteen-bit select register exactly.
	if (PINS < 1 || 2 * PINS > `PFS_SEL_W) begin : g_bad
		$error("pfs_top: PINS out of range");
	end

	logic [1:0][`PFS_SEL_W-1:0] sel;
	logic [1:0][`PFS_SEL_W-1:0] next_sel;
	logic [1:0][`PFS_PINS-1:0] dat;
	logic [1:0][`PFS_PINS-1:0] next_dat;
	logic [1:0][`PFS_PINS-1:0] sync1;
	logic [1:0][`PFS_PINS-1:0] sync2;
	logic [1:0][`PFS_PINS-1:0] view;
	pfs_pkg::pfs_pad_t [1:0] next_pad;
	logic wr_act;
	logic next_wr_act;
	pfs_pkg::pfs_reg_t wr_reg;
	pfs_pkg::pfs_reg_t next_wr_reg;
	logic [31:0] next_hrdata;
	logic acc;
	logic hit;
	pfs_pkg::pfs_reg_t idx;
	logic [1:0][`PFS_PINS-1:0] next_sync1;
	logic [1:0][`PFS_PINS-1:0] next_sync2;
	logic next_hreadyout;
	logic next_hresp;

	// Pins arrive from outside the clock domain; two stages before use.
	// Nothing but the second stage reads the first, so a metastable
	// first stage never reaches the mode logic.
	always_comb begin
		next_sync1 = pad_in;
		next_sync2 = sync1;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1 <= '0;
			sync2 <= '0;
		end else if (ce) begin
			sync1 <= next_sync1;
			sync2 <= next_sync2;
		end
	end

	assign alt_in = sync2;

	// Per-pin mode decode, shared by the pad drivers and the data read view.
	for (genvar p = 0; p < 2; p++) begin : g_port
		for (genvar i = 0; i < `PFS_PINS; i++) begin : g_pin
			if (i < PINS) begin : g_used
				pfs_pkg::pfs_mode_t md;
				assign md = pfs_pkg::pfs_mode_t'(next_sel[p][2*i+1 -: 2]);
				always_comb begin
					next_pad[p].out[i] = 1'b0;
					next_pad[p].oe[i] = 1'b0;
					next_pad[p].pu[i] = 1'b0;
					view[p][i] = sync2[p][i];
					case (md)
						pfs_pkg::PFS_MODE_ALT: begin
							// Alternate drive reaches the pad one edge late.
							next_pad[p].out[i] = alt[p].out[i];
							next_pad[p].oe[i] = alt[p].oe[i];
						end
						pfs_pkg::PFS_MODE_OUT: begin
							next_pad[p].out[i] = next_dat[p][i];
							next_pad[p].oe[i] = 1'b1;
							// An output pin reads back its latch, not the pad, so a
							// loaded pin cannot upset a read-modify-write.
							view[p][i] = next_dat[p][i];
						end
						pfs_pkg::PFS_MODE_IN_PU: begin
							next_pad[p].pu[i] = 1'b1;
						end
						pfs_pkg::PFS_MODE_IN_NOPU: begin
							next_pad[p].pu[i] = 1'b0;
						end
						default: begin
							next_pad[p].oe[i] = 1'b0;
						end
					endcase
				end
			end else begin : g_unused
				// Pins beyond PINS are parked: no drive, no pull-up, read zero.
				assign next_pad[p].out[i] = 1'b0;
				assign next_pad[p].oe[i] = 1'b0;
				assign next_pad[p].pu[i] = 1'b0;
				assign view[p][i] = 1'b0;
			end
		end
	end

	// Address decode of the four word registers.
	always_comb begin
		hit = 1'b1;
		idx = pfs_pkg::PFS_REG_SEL_A;
		case (haddr)
			`PFS_OFF_SEL_A: idx = pfs_pkg::PFS_REG_SEL_A;
			`PFS_OFF_SEL_B: idx = pfs_pkg::PFS_REG_SEL_B;
			`PFS_OFF_DAT_A: idx = pfs_pkg::PFS_REG_DAT_A;
			`PFS_OFF_DAT_B: idx = pfs_pkg::PFS_REG_DAT_B;
			default: hit = 1'b0;
		endcase
		// Taking only while hready is high keeps a stalled bus from
		// booking the same transfer twice.
		acc = hsel && hready && htrans[`PFS_HTRANS_NONSEQ_BIT];
	end

	// Register file: writes land in the data phase, reads are answered
	// from the values as they stand after any write in that same phase.
	always_comb begin
		next_sel = sel;
		next_dat = dat;
		if (wr_act) begin
			case (wr_reg)
				pfs_pkg::PFS_REG_SEL_A: next_sel[0] = hwdata[15:0];
				pfs_pkg::PFS_REG_SEL_B: next_sel[1] = hwdata[15:0];
				pfs_pkg::PFS_REG_DAT_A: next_dat[0] = hwdata[`PFS_PINS-1:0];
				pfs_pkg::PFS_REG_DAT_B: next_dat[1] = hwdata[`PFS_PINS-1:0];
				default: next_dat = dat;
			endcase
		end
	end

	// Bus front end. Narrow writes are dropped rather than merged, so a
	// stray byte store can never leave half a mode field behind.
	always_comb begin
		next_hreadyout = 1'b1;
		next_hresp = `PFS_HRESP_OKAY;
		next_wr_act = acc && hwrite && hit && hsize == `PFS_HSIZE_WORD;
		next_wr_reg = idx;
		next_hrdata = hrdata;
		if (acc && !hwrite) begin
			// Bits above a register's width read as zero.
			next_hrdata = 32'h0000_0000;
			if (hit) begin
				case (idx)
					pfs_pkg::PFS_REG_SEL_A: next_hrdata[15:0] = next_sel[0];
					pfs_pkg::PFS_REG_SEL_B: next_hrdata[15:0] = next_sel[1];
					pfs_pkg::PFS_REG_DAT_A: begin
						next_hrdata[`PFS_PINS-1:0] = view[0];
					end
					pfs_pkg::PFS_REG_DAT_B: begin
						next_hrdata[`PFS_PINS-1:0] = view[1];
					end
					default: next_hrdata = 32'h0000_0000;
				endcase
			end
		end
	end

	// Select and data latches.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sel <= {2{`PFS_SEL_RESET}};
			dat <= {2{`PFS_DAT_RESET}};
		end else if (ce) begin
			sel <= next_sel;
			dat <= next_dat;
		end
	end

	// Bus answer registers.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_act <= 1'b0;
			wr_reg <= pfs_pkg::PFS_REG_SEL_A;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= `PFS_HRESP_OKAY;
		end else if (ce) begin
			wr_act <= next_wr_act;
			wr_reg <= next_wr_reg;
			hrdata <= next_hrdata;
			hreadyout <= next_hreadyout;
			hresp <= next_hresp;
		end
	end

	// Registered so pads never glitch on a mode change.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pad <= '0;
		end else if (ce) begin
			pad <= next_pad;
		end
	end

endmodule : pfs_top

//--- pfs_top_props.sv
// Port checker of the pin function selector.
`timescale 1ns/1ns
module pfs_props (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic [1:0][7:0] pad_in,
	input wire pfs_pkg::pfs_pad_t [1:0] pad,
	input wire logic [1:0][7:0] alt_in
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence up_s; $rose(hresetn); endsequence
	sequence calm_s; (hresetn && $stable(pad_in)) [*3]; endsequence
	pu_drive_a: assert property ((pad[0].pu & pad[0].oe) == 8'h00)
		else $error("port A pull-up while driving");
	pu_drive_b_a: assert property ((pad[1].pu & pad[1].oe) == 8'h00)
		else $error("port B pull-up while driving");
	reset_pad_a: assert property (up_s |-> pad == 48'h0)
		else $error("pads not idle after reset");
	sync_in_a: assert property (calm_s |-> alt_in == pad_in)
		else $error("pin level not passed on");
	rd_hold_a: assert property (!(hsel && htrans[1] && !hwrite) |=>
		$stable(hrdata)) else $error("read data moved");
	rd_upper_a: assert property (hrdata[31:16] == 16'h0000)
		else $error("read data upper half not zero");
	bus_okay_a: assert property (hreadyout && hresp == 1'h0)
		else $error("bus answer stalled or not okay");
endmodule : pfs_props
bind pfs_top pfs_props pfs_props_i (.*);

//--- tb_pfs_top.sv
// Self-checking bench of the pin function selector.
`timescale 1ns/1ns
module tb_pfs_top;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0;
	logic [1:0][7:0] pad_in = 16'h0000;
	pfs_pkg::pfs_alt_t [1:0] alt = 32'h0;
	wire logic hreadyout, hresp;
	wire logic [31:0] hrdata;
	wire logic [1:0][7:0] alt_in;
	pfs_pkg::pfs_pad_t [1:0] pad;
	int fails = 0, n_tests = 0, cyc = 0;
	pfs_top pfs_top_i (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .pad_in(pad_in), .pad(pad),
		.alt(alt), .alt_in(alt_in));
	always #50 hclk = ~hclk;
	task results();
		$display("fails %0d n_tests %0d", fails, n_tests);
		if (fails == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : results
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			fails++;
			results();
		end
	end
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask : chk
	// Reads compare at the data-phase edge, before the next address is taken.
	task xfer(input logic w, input logic [31:0] a, d, input string n);
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		hsel <= 1'b1;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		if (!w) chk(n, d, hrdata);
	endtask : xfer
	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		alt <= 32'h0000_FFFF;
		pad_in <= 16'h00A5;
		@(posedge hclk);
		xfer(0, 32'h0, 32'h0, "sel A");
		xfer(0, 32'h4, 32'h0, "sel B");
		xfer(1, 32'h8, 32'hFF, "");
		xfer(1, 32'h0, 32'hFFFF_E4E4, "");
		xfer(1, 32'h4, 32'h1B1B, "");
		xfer(0, 32'h0, 32'hE4E4, "sel A");
		xfer(0, 32'h4, 32'h1B1B, "sel B");
		chk("oe A", 32'h33, {24'h0, pad[0].oe});
		chk("pu A", 32'h44, {24'h0, pad[0].pu});
		chk("oe B", 32'h44, {24'h0, pad[1].oe});
		chk("pu B", 32'h22, {24'h0, pad[1].pu});
		chk("out A", 32'h33, {24'h0, pad[0].out & 8'h33});
		chk("alt in", 32'hA5, {16'h0, alt_in});
		xfer(0, 32'h8, 32'hA7, "dat A");
		xfer(1, 32'hC, 32'hFF, "");
		xfer(0, 32'hC, 32'h44, "dat B");
		xfer(0, 32'h10, 32'h0, "unmapped");
		hresetn <= 1'b0;
		@(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		xfer(0, 32'h0, 32'h0, "sel A");
		results();
	end
endmodule : tb_pfs_top
